// ---- hdl/monreg_pkg.sv ----
/*
  Constants for the monitor register bank: offsets, reset values,
  field positions and channel counts.
  Assumes nothing of its surroundings; imported by the design files.
*/
package monreg_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h01;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h03;
  localparam logic [7:0] OFF_CONV_RATE = 8'h07;
  localparam logic [7:0] OFF_CHAN_OFF = 8'h08;
  localparam logic [7:0] OFF_SINGLE_PASS = 8'h09;
  localparam logic [7:0] OFF_DEEP_SLEEP = 8'h0A;
  localparam logic [7:0] OFF_REF_MODE = 8'h0B;
  localparam logic [7:0] OFF_BUSY = 8'h0C;
  localparam logic [7:0] OFF_RESULT_FIRST = 8'h20;
  localparam logic [7:0] OFF_RESULT_LAST = 8'h27;
  localparam logic [7:0] OFF_LIMIT_FIRST = 8'h2A;
  localparam logic [7:0] OFF_LIMIT_LAST = 8'h39;
  localparam logic [7:0] OFF_MAKER = 8'h3E;
  localparam logic [7:0] OFF_REVISION = 8'h3F;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BUSY = 8'h02;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int CFG_START_BIT = 0;
  localparam int CFG_IRQ_EN_BIT = 1;
  localparam int CFG_IRQ_CLR_BIT = 3;
  localparam int CFG_INIT_BIT = 7;
  localparam logic [7:0] CFG_WR_MASK = 8'h8B;
  localparam int BUSY_BUSY_BIT = 0;
  localparam int BUSY_NOT_READY_BIT = 1;
  localparam int HOT_CHANNEL = 7;

  // ==========================================================
  // Sizes
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_LIMITS = 16;
  localparam logic [7:0] RATE_CONT_BIT = 8'h01;

  // Identification codes; values arbitrary
  localparam logic [7:0] ID_MAKER_DEF = 8'h5A;
  localparam logic [7:0] ID_REVISION_DEF = 8'h3C;

endpackage

// ---- hdl/monreg_cmp_if.sv ----
/*
  Interface carrying one channel's reading and its limits to a
  window comparator, and the out-of-range verdict back.
  Assumes a single clock domain; purely combinational signals.
*/
`timescale 1ns/1ps

interface monreg_cmp_if;
  logic [15:0] reading;
  logic [7:0] high_limit;
  logic [7:0] low_limit;
  logic is_hot;
  logic fault;

  modport bank (output reading, output high_limit, output low_limit,
    output is_hot, input fault);
  modport cmp (input reading, input high_limit, input low_limit,
    input is_hot, output fault);
endinterface

// ---- hdl/monreg_cmp.sv ----
/*
  Window comparator for one channel.
  Assumes readings hold an 8-bit comparable value in bits 15:8
  and limits are unsigned (temperature: two's complement).
*/
`timescale 1ns/1ps

module monreg_cmp (
  monreg_cmp_if.cmp port_i
);
  import monreg_pkg::*;

  // ==========================================================
  // Compare top byte against the window
  logic [7:0] top;
  assign top = port_i.reading[15:8];

  // Hot: signed above threshold; others: above high or at/below low
  always_comb begin
    if (port_i.is_hot) begin
      port_i.fault = $signed(top) > $signed(port_i.high_limit);
    end else begin
      port_i.fault = (top > port_i.high_limit) ||
        (top <= port_i.low_limit);
    end
  end
endmodule

// ---- hdl/monreg_bank.sv ----
/*
  Register bank of an eight-channel monitor with window comparators,
  status and mask, a round-robin sequencer stub and interrupt output.
  Assumes a serial-bus front end that presents single-cycle read and
  write strobes with an 8-bit offset, and a converter that returns a
  16-bit result per channel with a done pulse.
*/
`timescale 1ns/1ps

module monreg_bank #(
  parameter logic [7:0] MAKER_CODE = monreg_pkg::ID_MAKER_DEF,
  parameter logic [7:0] REVISION_CODE = monreg_pkg::ID_REVISION_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic conv_start,
  output logic [2:0] conv_channel,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  output logic [7:0] conv_rate,
  output logic [7:0] ref_mode,
  output logic deep_sleep,
  output logic irq_n
);
  import monreg_pkg::*;

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    CONV = 3'b010,
    WAIT = 3'b100
  } monreg_seq_t;

  // ==========================================================
  // Register state
  logic [7:0] cfg_q;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [7:0] rate_q;
  logic [7:0] chan_off_q;
  logic [7:0] sleep_q;
  logic [7:0] ref_q;
  logic [7:0] busy_q;
  logic [15:0] result_q [NUM_CHANNELS];
  logic [7:0] limit_q [NUM_LIMITS];
  logic pass_req_q;
  monreg_seq_t seq_q;
  logic [2:0] chan_q;
  logic conv_start_q;
  logic irq_n_q;
  logic [15:0] rdata_q;
  logic rvalid_q;

  // Decoded strobes
  logic wr_cfg;
  logic init_req;
  logic rd_status;
  logic [NUM_CHANNELS-1:0] fault;
  logic loop_halt;
  logic [2:0] next_chan;
  logic next_found;
  logic [2:0] scan_base;

  // Hazards worth knowing before touching the sequencer:
  // - the channel search must start past the channel just converted,
  //   otherwise the loop keeps converting one channel forever
  // - every pass starts again at channel 0, so the not-ready flag clears
  //   only once channel 7 has been reached
  // - a one-shot request is honoured even while the loop is halted
  // - status bits are sticky; a read clears them, a new fault wins

  assign wr_cfg = reg_wr && (reg_addr == OFF_CONFIG);
  // Self-clearing initialisation request
  assign init_req = wr_cfg && reg_wdata[CFG_INIT_BIT];
  assign rd_status = reg_rd && (reg_addr == OFF_IRQ_STATUS);
  // Clear bit or stopped start bit holds the loop
  assign loop_halt = cfg_q[CFG_IRQ_CLR_BIT] ||
    !cfg_q[CFG_START_BIT];

  // ==========================================================
  // Window comparators, one per channel
  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : gen_cmp
    monreg_cmp_if cmp_port ();
    assign cmp_port.reading = result_q[g];
    // Hot channel uses its threshold pair; others their high/low pair
    assign cmp_port.high_limit = limit_q[2 * g];
    assign cmp_port.low_limit = limit_q[2 * g + 1];
    assign cmp_port.is_hot = (g == HOT_CHANNEL);
    assign fault[g] = cmp_port.fault;
    monreg_cmp u_cmp (
      .port_i(cmp_port)
    );
  end

  // ==========================================================
  // Configuration register, initialisation restores defaults
  always_ff @(posedge clk) begin
    if (sys_rst || init_req) begin
      cfg_q <= RST_CONFIG;
    end else if (wr_cfg) begin
      cfg_q <= reg_wdata & CFG_WR_MASK;
    end
  end

  // Plain read/write control registers
  always_ff @(posedge clk) begin
    if (sys_rst || init_req) begin
      mask_q <= RST_ZERO;
      rate_q <= RST_ZERO;
      chan_off_q <= RST_ZERO;
      sleep_q <= RST_ZERO;
      ref_q <= RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_IRQ_MASK: mask_q <= reg_wdata;
        OFF_CONV_RATE: rate_q <= reg_wdata;
        OFF_CHAN_OFF: chan_off_q <= reg_wdata;
        OFF_DEEP_SLEEP: sleep_q <= reg_wdata;
        OFF_REF_MODE: ref_q <= reg_wdata;
        default: ; // Read-only offsets ignore writes
      endcase
    end
  end

  // Limit registers
  always_ff @(posedge clk) begin
    if (sys_rst || init_req) begin
      for (int i = 0; i < NUM_LIMITS; i++) begin
        limit_q[i] <= RST_ZERO;
      end
    end else if (reg_wr && reg_addr >= OFF_LIMIT_FIRST &&
        reg_addr <= OFF_LIMIT_LAST) begin
      limit_q[4'(reg_addr - OFF_LIMIT_FIRST)] <= reg_wdata;
    end
  end

  // One-shot request latch, cleared whenever the sequencer is idle with a channel enabled
  always_ff @(posedge clk) begin
    if (sys_rst || init_req) begin
      pass_req_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_SINGLE_PASS) begin
      pass_req_q <= 1'b1;
    end else if (seq_q == IDLE && chan_off_q != 8'hFF) begin
      pass_req_q <= 1'b0;
    end
  end

  // ==========================================================
  // Next enabled channel; after a conversion the search starts
  // one past the channel just finished
  always_comb begin
    scan_base = (seq_q == WAIT) ? chan_q + 3'h1 : chan_q;
    next_chan = scan_base;
    next_found = 1'b0;
    for (int k = NUM_CHANNELS - 1; k >= 0; k--) begin
      if (!chan_off_q[3'(int'(scan_base) + k)]) begin
        next_chan = 3'(int'(scan_base) + k);
        next_found = 1'b1;
      end
    end
  end

  // Round-robin sequencer
  always_ff @(posedge clk) begin
    if (sys_rst || init_req) begin
      seq_q <= IDLE;
      chan_q <= 3'h0;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      case (seq_q)
        IDLE: begin
          // Continuous loop, or one pass on request
          if (next_found && !sleep_q[0] &&
              (pass_req_q || !loop_halt)) begin
            chan_q <= next_chan;
            conv_start_q <= 1'b1;
            seq_q <= CONV;
          end
        end
        CONV: begin
          if (conv_done) begin
            seq_q <= WAIT;
          end
        end
        WAIT: begin
          // Last channel ends a pass; loop resumes from channel 0
          if (chan_q == 3'h7) begin
            chan_q <= 3'h0;
            seq_q <= IDLE;
          end else if (!next_found || next_chan <= chan_q) begin
            // Search wrapped: no enabled channel left in this pass
            chan_q <= 3'h0;
            seq_q <= IDLE;
          end else begin
            chan_q <= next_chan;
            conv_start_q <= 1'b1;
            seq_q <= CONV;
          end
        end
        default: seq_q <= IDLE;
      endcase
    end
  end


  // Conversion results
  // Taken only while converting, so a stray done pulse is ignored
  always_ff @(posedge clk) begin
    if (sys_rst || init_req) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        result_q[i] <= RST_RESULT;
      end
    end else if (seq_q == CONV && conv_done) begin
      result_q[chan_q] <= conv_result;
    end
  end


  // Busy and not-ready flags; ready after the first pass that reaches channel 7
  // Busy follows the sequencer one cycle late
  always_ff @(posedge clk) begin
    if (sys_rst || init_req) begin
      busy_q <= RST_BUSY;
    end else begin
      busy_q[BUSY_BUSY_BIT] <= (seq_q != IDLE);
      if (seq_q == WAIT && seq_q != IDLE && chan_q == 3'h7) begin
        busy_q[BUSY_NOT_READY_BIT] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt status: set by comparator after a conversion,
  // cleared by read; a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst || init_req) begin
      status_q <= RST_ZERO;
    end else begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        if (seq_q == WAIT && chan_q == 3'(i) && fault[i]) begin
          status_q[i] <= 1'b1;
        end else if (rd_status) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end


  // Interrupt pin, active low, registered
  // Clear bit forces it high without touching the status bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !(!cfg_q[CFG_IRQ_CLR_BIT] &&
        cfg_q[CFG_IRQ_EN_BIT] &&
        |(status_q & ~mask_q));
    end
  end

  // ==========================================================
  // Read path, one cycle after the strobe
  // Eight-bit registers sit in the low byte, top byte zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        if (reg_addr >= OFF_RESULT_FIRST &&
            reg_addr <= OFF_RESULT_LAST) begin
          rdata_q <= result_q[reg_addr[2:0]];
        end else if (reg_addr >= OFF_LIMIT_FIRST &&
            reg_addr <= OFF_LIMIT_LAST) begin
          rdata_q <= {8'h00, limit_q[4'(reg_addr - OFF_LIMIT_FIRST)]};
        end else begin
          case (reg_addr)
            OFF_CONFIG: rdata_q <= {8'h00, cfg_q};
            OFF_IRQ_STATUS: rdata_q <= {8'h00, status_q};
            OFF_IRQ_MASK: rdata_q <= {8'h00, mask_q};
            OFF_CONV_RATE: rdata_q <= {8'h00, rate_q};
            OFF_CHAN_OFF: rdata_q <= {8'h00, chan_off_q};
            OFF_DEEP_SLEEP: rdata_q <= {8'h00, sleep_q};
            OFF_REF_MODE: rdata_q <= {8'h00, ref_q};
            OFF_BUSY: rdata_q <= {8'h00, busy_q};
            OFF_MAKER: rdata_q <= {8'h00, MAKER_CODE};
            OFF_REVISION: rdata_q <= {8'h00, REVISION_CODE};
            default: rdata_q <= 16'h0000;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign conv_start = conv_start_q;
  assign conv_channel = chan_q;
  assign conv_rate = rate_q;
  assign ref_mode = ref_q;
  assign deep_sleep = sleep_q[0];
  assign irq_n = irq_n_q;
endmodule

// ---- tb/monreg_checker.sv ----
/*
  Concurrent checks on the monitor register bank ports.
  Assumes binding onto monreg_bank; one clock, synchronous reset.
*/
`timescale 1ns/1ps

module monreg_checker #(
  parameter logic [7:0] MAKER_CODE = monreg_pkg::ID_MAKER_DEF,
  parameter logic [7:0] REVISION_CODE = monreg_pkg::ID_REVISION_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic conv_start,
  input wire logic [7:0] conv_rate,
  input wire logic [7:0] ref_mode,
  input wire logic deep_sleep,
  input wire logic irq_n
);
  import monreg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic cfg_wr;
  // ==========================================================
  // Register port checks
  assign cfg_wr = reg_wr && reg_addr == OFF_CONFIG;
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read gave no valid");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("valid without read");
  rate_copy_a: assert property (reg_wr && reg_addr == OFF_CONV_RATE
    |=> conv_rate == $past(reg_wdata)) else $error("rate not copied");
  mode_copy_a: assert property (reg_wr && reg_addr == OFF_REF_MODE
    |=> ref_mode == $past(reg_wdata)) else $error("mode not copied");
  sleep_copy_a: assert property (reg_wr && reg_addr == OFF_DEEP_SLEEP
    |=> deep_sleep == $past(reg_wdata[0])) else $error("sleep bad");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h3F
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  maker_read_a: assert property (reg_rd && reg_addr == OFF_MAKER
    |=> reg_rdata == {8'h00, MAKER_CODE}) else $error("maker code bad");
  rev_read_a: assert property (reg_rd && reg_addr == OFF_REVISION
    |=> reg_rdata == {8'h00, REVISION_CODE}) else $error("revision bad");
  clear_quiet_a: assert property (cfg_wr && reg_wdata[3]
    && !reg_wdata[7] ##1 !cfg_wr |=> irq_n) else $error("irq not cleared");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  // Main scenarios reached
  cover property (reg_rd && reg_addr == OFF_IRQ_STATUS && !irq_n);
  cover property (reg_wr && reg_addr == OFF_SINGLE_PASS);
  cover property (conv_start);
endmodule

bind monreg_bank monreg_checker #(.MAKER_CODE(MAKER_CODE),
  .REVISION_CODE(REVISION_CODE)) i_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .conv_start(conv_start), .conv_rate(conv_rate), .ref_mode(ref_mode),
  .deep_sleep(deep_sleep), .irq_n(irq_n));

// ---- tb/monreg_conv_model.sv ----
/*
  Behavioural converter facing the bank's conversion port.
  Assumes one clock; latency cycles through 1 to 5 per request.
*/
`timescale 1ns/1ps

module monreg_conv_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  output logic conv_done,
  output logic [15:0] conv_result
);
  logic [2:0] cnt_q;
  logic [2:0] lat_q;
  logic [2:0] ch_q;
  // Result known only with done; otherwise a toggling pattern
  always_ff @(posedge clk) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (sys_rst) begin
      cnt_q <= 3'h0;
      lat_q <= 3'h1;
      ch_q <= 3'h0;
      conv_result <= 16'hA5C3;
    end else if (conv_start) begin
      cnt_q <= lat_q;
      ch_q <= conv_channel;
      lat_q <= (lat_q == 3'h5) ? 3'h1 : lat_q + 3'h1;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) begin
        conv_done <= 1'b1;
        conv_result <= {1'b0, ch_q, 1'b1, ch_q, 5'h14, ch_q};
      end
    end
  end
endmodule

// ---- tb/monreg_bank_tb_top.sv ----
/*
  Self-checking bench for the monitor register bank.
  Assumes the converter model on the far side; 20 MHz clock.
*/
`timescale 1ns/1ps

module monreg_bank_tb_top;
  import monreg_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, conv_rate, ref_mode;
  logic [15:0] reg_rdata, conv_result;
  logic reg_rvalid, conv_start, conv_done, deep_sleep, irq_n;
  logic [2:0] conv_channel;
  logic [7:0] d;
  logic [15:0] v;
  int failures = 0, total_checks = 0, n;
  logic [7:0] rst_off [8] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h0A,
    8'h0B, 8'h0C};
  logic [7:0] rst_val [8] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h02};
  logic [7:0] rw_off [5] = '{8'h03, 8'h07, 8'h08, 8'h0A, 8'h0B};
  logic [7:0] ro_off [10] = '{8'h01, 8'h0C, 8'h20, 8'h27, 8'h3E, 8'h3F,
    8'h02, 8'h3D, 8'h40, 8'hFF};
  logic [7:0] ro_val [10] = '{8'h00, 8'h02, 8'h00, 8'h00, ID_MAKER_DEF,
    ID_REVISION_DEF, 8'h00, 8'h00, 8'h00, 8'h00};
  // ==========================================================
  // Clock, design and converter
  always #25 clk = ~clk;
  monreg_bank i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_result(conv_result), .conv_rate(conv_rate), .ref_mode(ref_mode),
    .deep_sleep(deep_sleep), .irq_n(irq_n));
  monreg_conv_model i_conv (.clk(clk), .sys_rst(sys_rst),
    .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_result(conv_result));
  // ==========================================================
  // Tasks and expectations
  function automatic logic [15:0] res(input logic [2:0] c);
    return {1'b0, c, 1'b1, c, 5'h14, c};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic results;
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk) reg_addr = a;
    reg_wdata = x;
    reg_wr = 1'b1;
    @(negedge clk) reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk) reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk) reg_rd = 1'b0;
    v = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
    chk("rdata", e, v);
  endtask
  task automatic wait_idle;
    repeat (2) @(negedge clk);
    for (n = 0; n < 300; n++) begin
      rd(OFF_BUSY);
      if (v[1:0] === 2'b00) break;
    end
    if (n == 300) begin
      failures++;
      results();
    end
    repeat (3) @(negedge clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h73D6));
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) rc(rst_off[i], {8'h00, rst_val[i]});
    chk("irq_n", 16'h0001, {15'h0, irq_n});
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom);
      wr(rw_off[i], d);
      rc(rw_off[i], {8'h00, d});
      if (i == 1) chk("conv_rate", {8'h00, d}, {8'h00, conv_rate});
      if (i == 3) chk("deep_sleep", {15'h0, d[0]}, {15'h0, deep_sleep});
      if (i == 4) chk("ref_mode", {8'h00, d}, {8'h00, ref_mode});
    end
    d = 8'($urandom) & 8'h0A;
    wr(OFF_CONFIG, d);
    rc(OFF_CONFIG, {8'h00, d});
    wr(OFF_CONFIG, 8'h80);
    rc(OFF_CONFIG, 16'h0008);
    chk("conv_rate", 16'h0000, {8'h00, conv_rate});
    for (int a = 8'h2A; a <= 8'h39; a++) begin
      d = 8'($urandom);
      wr(8'(a), d);
      rc(8'(a), {8'h00, d});
    end
    for (int i = 0; i < 10; i++) wr(ro_off[i], 8'hFF);
    for (int i = 0; i < 10; i++) rc(ro_off[i], {8'h00, ro_val[i]});
    for (int i = 0; i < 7; i++) begin
      wr(8'(8'h2A + 2 * i), 8'hFF);
      wr(8'(8'h2B + 2 * i), 8'h00);
    end
    wr(8'h2E, 8'h10);
    wr(8'h33, 8'h4C);
    wr(8'h34, 8'h00);
    wr(8'h38, 8'h7E);
    wr(OFF_CHAN_OFF, 8'h20);
    wr(OFF_CONFIG, 8'h02);
    wr(OFF_SINGLE_PASS, 8'h01);
    wait_idle();
    for (int i = 0; i < 8; i++) rc(8'(8'h20 + i), (i == 5) ? 16'h0 : res(3'(i)));
    chk("irq_n", 16'h0000, {15'h0, irq_n});
    rc(OFF_IRQ_STATUS, 16'h0094);
    repeat (2) @(negedge clk);
    chk("irq_n", 16'h0001, {15'h0, irq_n});
    rc(OFF_IRQ_STATUS, 16'h0000);
    wr(OFF_IRQ_MASK, 8'h94);
    wr(OFF_SINGLE_PASS, 8'h01);
    wait_idle();
    chk("irq_n", 16'h0001, {15'h0, irq_n});
    wr(OFF_IRQ_MASK, 8'h00);
    repeat (3) @(negedge clk);
    chk("irq_n", 16'h0000, {15'h0, irq_n});
    wr(OFF_CONFIG, 8'h00);
    repeat (3) @(negedge clk);
    chk("irq_n", 16'h0001, {15'h0, irq_n});
    wr(OFF_CONFIG, 8'h0A);
    repeat (3) @(negedge clk);
    chk("irq_n", 16'h0001, {15'h0, irq_n});
    rc(OFF_IRQ_STATUS, 16'h0094);
    wr(OFF_CONFIG, 8'h0B);
    d = 8'h00;
    repeat (60) @(negedge clk) d = d + 8'(conv_start);
    chk("halted", 16'h0000, {8'h00, d});
    wr(OFF_CONFIG, 8'h03);
    for (n = 0; n < 60 && conv_start !== 1'b1; n++) @(negedge clk);
    chk("loop_run", 16'h0001, {15'h0, n < 60});
    results();
  end
endmodule
